// >>> rtl/csd_regs.sv
`timescale 1ns/100ps
`default_nettype none

// Contract
// [RQ1] Synth reference clock power-down: 1 powers down, 0 enables; resets 0.
// [RQ2] Frame-ref control A bit 3 enables programmable hysteresis; resets 0.
// [RQ3] Frame-ref control A bit 2 selects rising edge of frame reference; resets 0.
// [RQ4] Hysteresis amount: [9:8] from control A [1:0], [7:0] from second register.
// [RQ5] Loop power bits 4 and 2 enable fine and coarse duty correction; reset 1.
// [RQ6] Loop power bits 3 and 1 enable fine and coarse cross control; reset 1.
// [RQ7] Loop power bit 0 powers down loop and clock generator; resets 1.
// [RQ8] Search direction field: 00 down, 01 up, 10 both; resets to 2.
// [RQ9] Mode 01 track only, 10 search only; error bits pick continue/restart, stop/retry.
// [RQ10] Loop control bit 0: 0 static settings, 1 feedback controller drives delays.
// [RQ11] Report lock achieved, lock lost and lock failed; lock-lost flag is writable.
module csd_regs #(
  parameter int unsigned HADDR_W = 32
) (
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               sys_rst,
  // AHB-Lite slave
  input  wire logic               hsel,
  input  wire logic [HADDR_W-1:0] haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire csd_pkg::csd_word_t hwdata,
  input  wire logic               hready,
  output var  csd_pkg::csd_word_t hrdata,
  output var  logic               hreadyout,
  output var  logic               hresp,
  // Loop sensing inputs from the analog side
  input  wire logic               loop_phase_in_range,
  input  wire logic               loop_search_exhausted,
  input  wire logic               loop_track_error,
  // Synthesizer and frame-reference controls
  output var  logic               synth_ref_clock_power_down,
  output var  logic               frame_ref_hysteresis_enable,
  output var  logic               frame_ref_rising_edge_select,
  output var  logic [9:0]         frame_ref_hysteresis_amount,
  // Delay loop controls
  output var  logic               fine_line_duty_correct_enable,
  output var  logic               fine_line_cross_ctrl_enable,
  output var  logic               coarse_line_duty_correct_enable,
  output var  logic               coarse_line_cross_ctrl_enable,
  output var  logic               delay_loop_power_down,
  output var  logic               loop_slope_positive,
  output var  logic [1:0]         loop_search_direction,
  output var  logic               loop_feedback_select,
  output var  logic               loop_searching,
  output var  logic               loop_tracking,
  output var  logic               loop_lock_achieved,
  // Interrupt
  output var  logic               irq
);
  import csd_pkg::*;

  if (HADDR_W < CSD_ADDR_W) begin
    $error("HADDR_W too narrow for the register map");
  end

  // ************************************************
  // Bus slave
  // ************************************************
  logic       req_ff;
  logic       req_wr_ff;
  csd_addr_t  req_addr_ff;
  logic       take;
  logic       wr_now;
  logic       rd_now;
  csd_byte_t  rd_byte;

  assign take   = hsel & htrans[1] & hready;
  assign wr_now = req_ff & req_wr_ff;
  assign rd_now = req_ff & ~req_wr_ff;

  // One wait state: write lands and read data is captured in that cycle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      req_ff      <= 1'b0;
      req_wr_ff   <= 1'b0;
      req_addr_ff <= '0;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (req_ff) begin
        req_ff    <= 1'b0;
        hreadyout <= 1'b1;
      end else if (take) begin
        req_ff      <= 1'b1;
        req_wr_ff   <= hwrite;
        req_addr_ff <= haddr[CSD_ADDR_W-1:0];
        hreadyout   <= 1'b0;
      end
    end
  end

  // ************************************************
  // Configuration registers
  // ************************************************
  csd_byte_t synth_ref_ff;
  csd_byte_t frame_a_ff;
  csd_byte_t frame_hys_ff;
  csd_byte_t loop_pwr_ff;
  csd_byte_t loop_cfg_ff;
  csd_byte_t irq_mask_ff;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      synth_ref_ff <= CSD_RST_SYNTH_REF; // see [RQ1]
      frame_a_ff   <= CSD_RST_FRAME_A;
      frame_hys_ff <= CSD_RST_FRAME_HYS;
      loop_pwr_ff  <= CSD_RST_LOOP_PWR;  // see [RQ5] see [RQ6] see [RQ7]
      loop_cfg_ff  <= CSD_RST_LOOP_CFG;  // see [RQ8]
      irq_mask_ff  <= CSD_RST_IRQ_MASK;
    end else if (wr_now) begin
      case (req_addr_ff)
        CSD_ADR_SYNTH_REF: synth_ref_ff <= {7'h00, hwdata[CSD_B_SYNTH_PD]};
        CSD_ADR_FRAME_A:   frame_a_ff   <= {4'h0, hwdata[3:0]};
        CSD_ADR_FRAME_HYS: frame_hys_ff <= hwdata[7:0];
        CSD_ADR_LOOP_PWR:  loop_pwr_ff  <= {3'h0, hwdata[4:0]};
        CSD_ADR_LOOP_CFG:  loop_cfg_ff  <= hwdata[7:0];
        CSD_ADR_IRQ_MASK:  irq_mask_ff  <= {5'h00, hwdata[2:0]};
        default: begin
        end
      endcase
    end
  end

  // ************************************************
  // Control outputs
  // ************************************************
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      synth_ref_clock_power_down      <= CSD_RST_SYNTH_REF[CSD_B_SYNTH_PD];
      frame_ref_hysteresis_enable     <= CSD_RST_FRAME_A[CSD_B_HYS_EN];
      frame_ref_rising_edge_select    <= CSD_RST_FRAME_A[CSD_B_RISE];
      frame_ref_hysteresis_amount     <= '0;
      fine_line_duty_correct_enable   <= CSD_RST_LOOP_PWR[CSD_B_FINE_DC];
      fine_line_cross_ctrl_enable     <= CSD_RST_LOOP_PWR[CSD_B_FINE_XC];
      coarse_line_duty_correct_enable <= CSD_RST_LOOP_PWR[CSD_B_COARSE_DC];
      coarse_line_cross_ctrl_enable   <= CSD_RST_LOOP_PWR[CSD_B_COARSE_XC];
      delay_loop_power_down           <= CSD_RST_LOOP_PWR[CSD_B_LOOP_PD];
      loop_slope_positive             <= CSD_RST_LOOP_CFG[CSD_B_SLOPE];
      loop_search_direction           <= CSD_RST_LOOP_CFG[CSD_B_DIR_LSB +: 2];
      loop_feedback_select            <= CSD_RST_LOOP_CFG[CSD_B_CTRL_EN];
    end else begin
      synth_ref_clock_power_down      <= synth_ref_ff[CSD_B_SYNTH_PD]; // see [RQ1]
      frame_ref_hysteresis_enable     <= frame_a_ff[CSD_B_HYS_EN];     // see [RQ2]
      frame_ref_rising_edge_select    <= frame_a_ff[CSD_B_RISE];       // see [RQ3]
      frame_ref_hysteresis_amount     <= {frame_a_ff[CSD_B_HYS_HI_LSB +: CSD_HYS_HI_W], frame_hys_ff}; // see [RQ4]
      fine_line_duty_correct_enable   <= loop_pwr_ff[CSD_B_FINE_DC];   // see [RQ5]
      fine_line_cross_ctrl_enable     <= loop_pwr_ff[CSD_B_FINE_XC];   // see [RQ6]
      coarse_line_duty_correct_enable <= loop_pwr_ff[CSD_B_COARSE_DC]; // see [RQ5]
      coarse_line_cross_ctrl_enable   <= loop_pwr_ff[CSD_B_COARSE_XC]; // see [RQ6]
      delay_loop_power_down           <= loop_pwr_ff[CSD_B_LOOP_PD];   // see [RQ7]
      loop_slope_positive             <= loop_cfg_ff[CSD_B_SLOPE];
      loop_search_direction           <= loop_cfg_ff[CSD_B_DIR_LSB +: 2]; // see [RQ8]
      loop_feedback_select            <= loop_cfg_ff[CSD_B_CTRL_EN];   // see [RQ10]
    end
  end

  // ************************************************
  // Input synchronisers
  // ************************************************
  logic [CSD_SYNC_W-1:0] sync1_ff;
  logic [CSD_SYNC_W-1:0] sync2_ff;
  logic [CSD_SYNC_W-1:0] sync3_ff;
  logic [CSD_SYNC_W-1:0] sense_ff;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
      sense_ff <= '0;
    end else begin
      sync1_ff <= {loop_track_error, loop_search_exhausted, loop_phase_in_range};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      for (int i = 0; i < CSD_SYNC_W; i++) begin
        if (sync2_ff[i] == sync3_ff[i]) begin
          sense_ff[i] <= sync3_ff[i];
        end
      end
    end
  end

  logic in_range;
  logic exhausted;
  logic trk_err;
  assign in_range  = sense_ff[0];
  assign exhausted = sense_ff[1];
  assign trk_err   = sense_ff[2];

  // ************************************************
  // Loop controller
  // ************************************************
  csd_state_t state_ff;
  csd_state_t nxt_state;
  logic       run;
  logic [1:0] mode;
  logic       ev_lost;
  logic       ev_fail;

  // Controller runs only when powered and selected as delay source
  assign run  = ~loop_pwr_ff[CSD_B_LOOP_PD] & loop_cfg_ff[CSD_B_CTRL_EN]; // see [RQ7] see [RQ10]
  assign mode = loop_cfg_ff[CSD_B_MODE_LSB +: 2];

  always_comb begin
    nxt_state = state_ff;
    ev_lost   = 1'b0;
    ev_fail   = 1'b0;
    case (state_ff)
      CSD_ST_IDLE: begin
        if (run) begin
          nxt_state = (mode == CSD_MODE_TRACK) ? CSD_ST_TRACK : CSD_ST_SEARCH; // see [RQ9]
        end
      end
      CSD_ST_SEARCH: begin
        if (in_range) begin
          nxt_state = (mode == CSD_MODE_SEARCH) ? CSD_ST_HOLD : CSD_ST_TRACK; // see [RQ9]
        end else if (exhausted) begin
          ev_fail = 1'b1;
          if (!loop_cfg_ff[CSD_B_SEARCH_ERR]) begin
            nxt_state = CSD_ST_FAIL; // see [RQ9]
          end
        end
      end
      CSD_ST_TRACK: begin
        if (trk_err) begin
          ev_lost = 1'b1;
          if (loop_cfg_ff[CSD_B_TRACK_ERR] && mode != CSD_MODE_TRACK) begin
            nxt_state = CSD_ST_SEARCH; // see [RQ9]
          end
        end
      end
      CSD_ST_HOLD: begin
      end
      CSD_ST_FAIL: begin
      end
      default: begin
        nxt_state = CSD_ST_IDLE;
      end
    endcase
    if (!run) begin
      nxt_state = CSD_ST_IDLE;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_ff <= CSD_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      loop_searching <= 1'b0;
      loop_tracking  <= 1'b0;
    end else begin
      loop_searching <= (nxt_state == CSD_ST_SEARCH);
      loop_tracking  <= (nxt_state == CSD_ST_TRACK);
    end
  end

  // ************************************************
  // Loop status flags
  // ************************************************
  logic lost_ff;
  logic fail_ff;
  logic lock_rise;
  logic nxt_locked;

  assign nxt_locked = ((nxt_state == CSD_ST_TRACK) || (nxt_state == CSD_ST_HOLD)) & ~ev_lost;
  assign lock_rise  = nxt_locked & ~loop_lock_achieved;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      loop_lock_achieved <= 1'b0;
    end else begin
      loop_lock_achieved <= nxt_locked; // see [RQ11]
    end
  end

  // Hardware set wins over a software write
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lost_ff <= 1'b0;
    end else if (ev_lost) begin
      lost_ff <= 1'b1; // see [RQ11]
    end else if (wr_now && req_addr_ff == CSD_ADR_LOOP_STAT) begin
      lost_ff <= hwdata[CSD_B_LOST]; // see [RQ11]
    end
  end

  // Failed stays until the controller is restarted
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      fail_ff <= 1'b0;
    end else if (ev_fail) begin
      fail_ff <= 1'b1; // see [RQ11]
    end else if (state_ff == CSD_ST_IDLE && run) begin
      fail_ff <= 1'b0;
    end
  end

  // ************************************************
  // Interrupt status, mask and output
  // ************************************************
  logic [2:0] irq_stat_ff;
  logic [2:0] irq_set;
  logic       stat_rd;

  assign irq_set = {ev_fail, ev_lost, lock_rise};
  assign stat_rd = rd_now && (req_addr_ff == CSD_ADR_IRQ_STAT);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq_stat_ff <= '0;
    end else if (stat_rd) begin
      irq_stat_ff <= irq_set;
    end else begin
      irq_stat_ff <= irq_stat_ff | irq_set;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_ff & irq_mask_ff[2:0]);
    end
  end

  // ************************************************
  // Read data
  // ************************************************
  always_comb begin
    case (req_addr_ff)
      CSD_ADR_SYNTH_REF: rd_byte = synth_ref_ff;
      CSD_ADR_FRAME_A:   rd_byte = frame_a_ff;
      CSD_ADR_FRAME_HYS: rd_byte = frame_hys_ff;
      CSD_ADR_LOOP_PWR:  rd_byte = loop_pwr_ff;
      CSD_ADR_LOOP_CFG:  rd_byte = loop_cfg_ff;
      CSD_ADR_LOOP_STAT: rd_byte = {5'h00, fail_ff, lost_ff, loop_lock_achieved}; // see [RQ11]
      CSD_ADR_IRQ_STAT:  rd_byte = {5'h00, irq_stat_ff};
      CSD_ADR_IRQ_MASK:  rd_byte = irq_mask_ff;
      default:           rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      hrdata <= '0;
    end else if (rd_now) begin
      hrdata <= {24'h000000, rd_byte};
    end
  end

endmodule

`default_nettype wire

// >>> include/csd_pkg.sv
`default_nettype none
package csd_pkg;

  // ************************************************
  // Bus widths and types
  // ************************************************
  localparam int unsigned CSD_ADDR_W = 12;
  localparam int unsigned CSD_DATA_W = 32;
  typedef logic [CSD_ADDR_W-1:0] csd_addr_t;
  typedef logic [CSD_DATA_W-1:0] csd_word_t;
  typedef logic [7:0]            csd_byte_t;

  // ************************************************
  // Register indices and byte addresses
  // ************************************************
  localparam csd_addr_t CSD_IDX_SYNTH_REF  = 12'h084;
  localparam csd_addr_t CSD_IDX_FRAME_A    = 12'h088;
  localparam csd_addr_t CSD_IDX_FRAME_HYS  = 12'h089;
  localparam csd_addr_t CSD_IDX_LOOP_PWR   = 12'h090;
  localparam csd_addr_t CSD_IDX_LOOP_CFG   = 12'h091;
  localparam csd_addr_t CSD_IDX_LOOP_STAT  = 12'h092;
  localparam csd_addr_t CSD_IDX_IRQ_STAT   = 12'h0a0;
  localparam csd_addr_t CSD_IDX_IRQ_MASK   = 12'h0a1;
  localparam csd_addr_t CSD_ADR_SYNTH_REF  = CSD_ADDR_W'(CSD_IDX_SYNTH_REF * 4);
  localparam csd_addr_t CSD_ADR_FRAME_A    = CSD_ADDR_W'(CSD_IDX_FRAME_A * 4);
  localparam csd_addr_t CSD_ADR_FRAME_HYS  = CSD_ADDR_W'(CSD_IDX_FRAME_HYS * 4);
  localparam csd_addr_t CSD_ADR_LOOP_PWR   = CSD_ADDR_W'(CSD_IDX_LOOP_PWR * 4);
  localparam csd_addr_t CSD_ADR_LOOP_CFG   = CSD_ADDR_W'(CSD_IDX_LOOP_CFG * 4);
  localparam csd_addr_t CSD_ADR_LOOP_STAT  = CSD_ADDR_W'(CSD_IDX_LOOP_STAT * 4);
  localparam csd_addr_t CSD_ADR_IRQ_STAT   = CSD_ADDR_W'(CSD_IDX_IRQ_STAT * 4);
  localparam csd_addr_t CSD_ADR_IRQ_MASK   = CSD_ADDR_W'(CSD_IDX_IRQ_MASK * 4);

  // ************************************************
  // Reset values
  // ************************************************
  localparam csd_byte_t CSD_RST_SYNTH_REF  = 8'h00;
  localparam csd_byte_t CSD_RST_FRAME_A    = 8'h00;
  localparam csd_byte_t CSD_RST_FRAME_HYS  = 8'h00;
  localparam csd_byte_t CSD_RST_LOOP_PWR   = 8'h1f;
  localparam csd_byte_t CSD_RST_LOOP_CFG   = 8'hf0;
  localparam csd_byte_t CSD_RST_IRQ_MASK   = 8'h00;

  // ************************************************
  // Field positions
  // ************************************************
  localparam int unsigned CSD_B_SYNTH_PD   = 0;
  localparam int unsigned CSD_B_HYS_EN     = 3;
  localparam int unsigned CSD_B_RISE       = 2;
  localparam int unsigned CSD_B_HYS_HI_LSB = 0;
  localparam int unsigned CSD_HYS_HI_W     = 2;
  localparam int unsigned CSD_B_FINE_DC    = 4;
  localparam int unsigned CSD_B_FINE_XC    = 3;
  localparam int unsigned CSD_B_COARSE_DC  = 2;
  localparam int unsigned CSD_B_COARSE_XC  = 1;
  localparam int unsigned CSD_B_LOOP_PD    = 0;
  localparam int unsigned CSD_B_TRACK_ERR  = 7;
  localparam int unsigned CSD_B_SEARCH_ERR = 6;
  localparam int unsigned CSD_B_SLOPE      = 5;
  localparam int unsigned CSD_B_DIR_LSB    = 3;
  localparam int unsigned CSD_B_MODE_LSB   = 1;
  localparam int unsigned CSD_B_CTRL_EN    = 0;
  localparam int unsigned CSD_B_LOCKED     = 0;
  localparam int unsigned CSD_B_LOST       = 1;
  localparam int unsigned CSD_B_FAILED     = 2;

  // ************************************************
  // Modes, directions and states
  // ************************************************
  localparam logic [1:0] CSD_MODE_TRACK    = 2'h1;
  localparam logic [1:0] CSD_MODE_SEARCH   = 2'h2;
  localparam logic [1:0] CSD_DIR_DOWN      = 2'h0;
  localparam logic [1:0] CSD_DIR_UP        = 2'h1;
  localparam logic [1:0] CSD_DIR_BOTH      = 2'h2;
  localparam logic [1:0] CSD_HTRANS_NONSEQ = 2'h2;
  localparam int unsigned CSD_SYNC_W       = 3;

  typedef enum logic [2:0] {
    CSD_ST_IDLE   = 3'h0,
    CSD_ST_SEARCH = 3'h1,
    CSD_ST_TRACK  = 3'h3,
    CSD_ST_HOLD   = 3'h2,
    CSD_ST_FAIL   = 3'h6
  } csd_state_t;

endpackage
`default_nettype wire

// >>> bench/csd_regs_props.sv
`timescale 1ns/100ps
`default_nettype none
module csd_regs_props
  import csd_pkg::*;
#(
  parameter int unsigned HADDR_W = 32
) (
  // Clock, reset and bus
  input wire logic               clock,
  input wire logic               sys_rst,
  input wire logic               hsel,
  input wire logic [HADDR_W-1:0] haddr,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire csd_word_t          hwdata,
  input wire logic               hready,
  input wire csd_word_t          hrdata,
  input wire logic               hreadyout,
  input wire logic               hresp,
  // Configuration outputs
  input wire logic               synth_ref_clock_power_down,
  input wire logic               frame_ref_hysteresis_enable,
  input wire logic               frame_ref_rising_edge_select,
  input wire logic [9:0]         frame_ref_hysteresis_amount,
  input wire logic               fine_line_duty_correct_enable,
  input wire logic               fine_line_cross_ctrl_enable,
  input wire logic               coarse_line_duty_correct_enable,
  input wire logic               coarse_line_cross_ctrl_enable,
  input wire logic               delay_loop_power_down,
  input wire logic [1:0]         loop_search_direction,
  input wire logic               loop_feedback_select,
  input wire logic               loop_searching,
  input wire logic               loop_tracking,
  input wire logic               loop_lock_achieved,
  input wire logic               irq
);
  logic      take;
  logic      wr_en;
  csd_word_t wd_ff;
  csd_word_t wd2_ff;

  assign take  = hsel && htrans[1] && hready;
  assign wr_en = take && hwrite;

  // Write data as it stood in the data phase, two edges late
  always_ff @(posedge clock) begin
    wd_ff  <= hwdata;
    wd2_ff <= wd_ff;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_bus_wait_state: assert property (take |=> !hreadyout ##1 hreadyout)
    else $error("wait state not exactly one cycle");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  a_read_upper_zero: assert property (take && !hwrite |=> ##1 hrdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_synth_pd_map: assert property (
    wr_en && haddr == HADDR_W'(CSD_ADR_SYNTH_REF) |=> ##2 synth_ref_clock_power_down == wd2_ff[0])
    else $error("synth power down does not follow write");
  a_frame_a_map: assert property (
    wr_en && haddr == HADDR_W'(CSD_ADR_FRAME_A) |=> ##2
    {frame_ref_hysteresis_enable, frame_ref_rising_edge_select, frame_ref_hysteresis_amount[9:8]} == wd2_ff[3:0])
    else $error("frame control does not follow write");
  a_hyst_low_map: assert property (
    wr_en && haddr == HADDR_W'(CSD_ADR_FRAME_HYS) |=> ##2 frame_ref_hysteresis_amount[7:0] == wd2_ff[7:0])
    else $error("hysteresis low byte does not follow write");
  a_loop_pwr_map: assert property (
    wr_en && haddr == HADDR_W'(CSD_ADR_LOOP_PWR) |=> ##2
    {fine_line_duty_correct_enable, fine_line_cross_ctrl_enable, coarse_line_duty_correct_enable,
     coarse_line_cross_ctrl_enable, delay_loop_power_down} == wd2_ff[4:0])
    else $error("loop power outputs do not follow write");
  a_loop_cfg_map: assert property (
    wr_en && haddr == HADDR_W'(CSD_ADR_LOOP_CFG) |=> ##2
    {loop_search_direction, loop_feedback_select} == {wd2_ff[4:3], wd2_ff[0]})
    else $error("loop config outputs do not follow write");
  a_reset_values: assert property ($fell(sys_rst) |->
    delay_loop_power_down && fine_line_duty_correct_enable && fine_line_cross_ctrl_enable
    && coarse_line_duty_correct_enable && coarse_line_cross_ctrl_enable && loop_search_direction == 2'h2
    && !synth_ref_clock_power_down && !frame_ref_hysteresis_enable && frame_ref_hysteresis_amount == 10'h0
    && !loop_feedback_select && !irq && hreadyout)
    else $error("outputs not at reset values");
  a_idle_when_off: assert property (
    (delay_loop_power_down || !loop_feedback_select) [*3] |-> !loop_searching && !loop_tracking)
    else $error("controller active while off");
  a_lock_exclusive: assert property (loop_searching |-> !loop_lock_achieved && !loop_tracking)
    else $error("lock reported while searching");
endmodule

bind csd_regs csd_regs_props #(.HADDR_W(HADDR_W)) u_props (
  .clock, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
  .synth_ref_clock_power_down, .frame_ref_hysteresis_enable, .frame_ref_rising_edge_select,
  .frame_ref_hysteresis_amount, .fine_line_duty_correct_enable, .fine_line_cross_ctrl_enable,
  .coarse_line_duty_correct_enable, .coarse_line_cross_ctrl_enable, .delay_loop_power_down,
  .loop_search_direction, .loop_feedback_select, .loop_searching, .loop_tracking, .loop_lock_achieved, .irq
);
`default_nettype wire

// >>> bench/tb_clock_sysref_dll_config_regs.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end
module tb_clock_sysref_dll_config_regs;
  import csd_pkg::*;
  logic        clock, sys_rst, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [31:0] haddr;
  logic [1:0]  htrans, dir;
  csd_word_t   hwdata, hrdata;
  logic        in_rng, exh, trk_err, synth_pd, hys_en, rise, fbsel, srch, trk, lock, slope;
  logic [4:0]  pwr;
  logic [9:0]  hys_amt;
  int          num_errors, tests_run, cycles;

  assign hready = hreadyout;

  csd_regs u_dut (
    .clock, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout,
    .hresp, .loop_phase_in_range(in_rng), .loop_search_exhausted(exh), .loop_track_error(trk_err),
    .synth_ref_clock_power_down(synth_pd), .frame_ref_hysteresis_enable(hys_en),
    .frame_ref_rising_edge_select(rise), .frame_ref_hysteresis_amount(hys_amt),
    .fine_line_duty_correct_enable(pwr[4]), .fine_line_cross_ctrl_enable(pwr[3]),
    .coarse_line_duty_correct_enable(pwr[2]), .coarse_line_cross_ctrl_enable(pwr[1]),
    .delay_loop_power_down(pwr[0]), .loop_slope_positive(slope), .loop_search_direction(dir),
    .loop_feedback_select(fbsel), .loop_searching(srch), .loop_tracking(trk), .loop_lock_achieved(lock),
    .irq
  );

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      finish_test();
    end
  end

  task automatic tick(int n);
    repeat (n) @(posedge clock);
  endtask

  // Single AHB-Lite transfer, waits on hready at both phases
  task automatic ahb(logic wr, csd_addr_t a, csd_word_t d, output csd_word_t q);
    hsel <= 1'b1;
    htrans <= CSD_HTRANS_NONSEQ;
    haddr <= 32'(a);
    hwrite <= wr;
    do @(posedge clock); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(csd_addr_t a, csd_byte_t d);
    csd_word_t q;
    ahb(1'b1, a, {24'h0, d}, q);
  endtask

  task automatic rd_chk(string nm, csd_addr_t a, csd_byte_t e);
    csd_word_t q;
    ahb(1'b0, a, 32'h0, q);
    `CHK(nm, {24'h0, e}, q)
  endtask

  task automatic t_reset();
    rd_chk("synth ref", CSD_ADR_SYNTH_REF, 8'h00);
    rd_chk("frame a", CSD_ADR_FRAME_A, 8'h00);
    rd_chk("hys low", CSD_ADR_FRAME_HYS, 8'h00);
    rd_chk("loop pwr", CSD_ADR_LOOP_PWR, 8'h1f);
    rd_chk("loop cfg", CSD_ADR_LOOP_CFG, 8'hf0);
    rd_chk("loop stat", CSD_ADR_LOOP_STAT, 8'h00);
    rd_chk("unmapped", 12'h3fc, 8'h00);
    `CHK("pwr outs", 5'h1f, pwr)
    `CHK("dir out", 2'h2, dir)
    `CHK("slope rst", 1'b1, slope)
    $display("test reset done");
  endtask

  task automatic t_config();
    wr(CSD_ADR_FRAME_A, 8'hff);
    wr(CSD_ADR_FRAME_HYS, 8'ha5);
    rd_chk("frame a rsvd", CSD_ADR_FRAME_A, 8'h0f);
    `CHK("frame_ref_hysteresis_enable", 3'h7, {hys_en, rise, 1'b1})
    `CHK("hys amt", 10'h3a5, hys_amt)
    wr(CSD_ADR_FRAME_A, 8'h06);
    tick(2);
    `CHK("hys off", 3'h3, {hys_en, rise, 1'b1})
    `CHK("hys amt hi", 10'h2a5, hys_amt)
    wr(CSD_ADR_SYNTH_REF, 8'h01);
    tick(2);
    `CHK("synth pd", 1'b1, synth_pd)
    wr(CSD_ADR_SYNTH_REF, 8'h00);
    tick(2);
    `CHK("synth on", 1'b0, synth_pd)
    wr(CSD_ADR_LOOP_PWR, 8'hea);
    rd_chk("pwr rsvd", CSD_ADR_LOOP_PWR, 8'h0a);
    `CHK("pwr a", 5'h0a, pwr)
    wr(CSD_ADR_LOOP_PWR, 8'h15);
    tick(2);
    `CHK("pwr b", 5'h15, pwr)
    for (int d = 0; d < 3; d++) begin
      wr(CSD_ADR_LOOP_CFG, {2'h3, 1'(d), 2'(d), 2'h0, 1'(d)});
      tick(2);
      `CHK("dir fb", {1'(d), 2'(d), 1'(d)}, {slope, dir, fbsel})
    end
    $display("test config done");
  endtask

  task automatic t_loop();
    wr(CSD_ADR_IRQ_MASK, 8'h01);
    wr(CSD_ADR_LOOP_PWR, 8'h1e);
    wr(CSD_ADR_LOOP_CFG, 8'h35);
    tick(12);
    `CHK("searching", 3'h4, {srch, trk, lock})
    in_rng <= 1'b1;
    tick(12);
    `CHK("hold", 3'h1, {srch, trk, lock})
    `CHK("irq lock", 1'b1, irq)
    rd_chk("stat lock", CSD_ADR_LOOP_STAT, 8'h01);
    rd_chk("irq stat", CSD_ADR_IRQ_STAT, 8'h01);
    rd_chk("irq clr", CSD_ADR_IRQ_STAT, 8'h00);
    tick(2);
    `CHK("irq low", 1'b0, irq)
    wr(CSD_ADR_LOOP_CFG, 8'h34);
    in_rng <= 1'b0;
    exh <= 1'b1;
    tick(12);
    wr(CSD_ADR_LOOP_CFG, 8'h35);
    tick(12);
    `CHK("failed", 3'h0, {srch, trk, lock})
    rd_chk("stat fail", CSD_ADR_LOOP_STAT, 8'h04);
    `CHK("irq masked", 1'b0, irq)
    rd_chk("irq fail", CSD_ADR_IRQ_STAT, 8'h04);
    exh <= 1'b0;
    wr(CSD_ADR_IRQ_MASK, 8'h02);
    wr(CSD_ADR_LOOP_CFG, 8'h34);
    wr(CSD_ADR_LOOP_CFG, 8'h33);
    tick(12);
    `CHK("tracking", 3'h3, {srch, trk, lock})
    trk_err <= 1'b1;
    tick(12);
    `CHK("continue", 4'h5, {srch, trk, lock, irq})
    rd_chk("stat lost", CSD_ADR_LOOP_STAT, 8'h02);
    trk_err <= 1'b0;
    tick(12);
    wr(CSD_ADR_LOOP_STAT, 8'h00);
    rd_chk("lost clr", CSD_ADR_LOOP_STAT, 8'h01);
    rd_chk("irq lost", CSD_ADR_IRQ_STAT, 8'h03);
    tick(2);
    `CHK("irq off", 1'b0, irq)
    wr(CSD_ADR_LOOP_CFG, 8'h34);
    exh <= 1'b1;
    wr(CSD_ADR_LOOP_CFG, 8'h75);
    tick(12);
    `CHK("retry", 3'h4, {srch, trk, lock})
    exh <= 1'b0;
    in_rng <= 1'b1;
    wr(CSD_ADR_LOOP_CFG, 8'h34);
    wr(CSD_ADR_LOOP_CFG, 8'hb1);
    tick(12);
    `CHK("mode 00", 3'h3, {srch, trk, lock})
    in_rng <= 1'b0;
    trk_err <= 1'b1;
    tick(12);
    `CHK("restart", 3'h4, {srch, trk, lock})
    $display("test loop done");
  endtask

  initial begin
    {hsel, hwrite, in_rng, exh, trk_err} = '0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwdata = 32'h0;
    sys_rst = 1'b1;
    num_errors = 0;
    tests_run = 0;
    cycles = 0;
    tick(3);
    sys_rst <= 1'b0;
    tick(1);
    t_reset();
    t_config();
    t_loop();
    finish_test();
  end
endmodule
`default_nettype wire
